// >>> verilog/line_video_pkg.sv
// Constants and types for the four-tap line video output block
`default_nettype none
package line_video_pkg;
  // ==========================================================================
  // Widths
  localparam int PIX_W = 12;
  localparam int WORD_W = 48;
  localparam int FIFO_DEPTH = 16;
  localparam int LVL_W = 5;
  localparam int LEN_W = 14;
  localparam int GRP_W = 12;
  localparam int CNT_W = 16;

  // ==========================================================================
  // Register byte addresses
  localparam logic [31:0] CTRL_ADDR = 32'h0000_0000;
  localparam logic [31:0] WIN_ADDR = 32'h0000_0004;
  localparam logic [31:0] STAT_ADDR = 32'h0000_0008;

  // Control fields and reset value (enabled, 12 bit, 2k variant)
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_VAR_LSB = 2;
  localparam int CTRL_BIN_BIT = 4;
  localparam int CTRL_WIN_BIT = 5;
  localparam int CTRL_EN_BIT = 6;
  localparam logic [6:0] CTRL_RST = 7'h40;
  localparam logic [LEN_W-1:0] WIN_RST = 14'h0800;

  // Status fields
  localparam int ST_ACTIVE_BIT = 0;
  localparam int ST_UNDER_BIT = 1;
  localparam int ST_LEVEL_LSB = 2;
  localparam int ST_COUNT_LSB = 16;

  // ==========================================================================
  // Output modes and sensor variants
  localparam logic [1:0] MODE_12 = 2'h0;
  localparam logic [1:0] MODE_10 = 2'h1;
  localparam logic [1:0] MODE_8 = 2'h2;
  localparam logic [1:0] VAR_2K = 2'h0;
  localparam logic [1:0] VAR_4K = 2'h1;
  localparam logic [1:0] VAR_8K = 2'h2;

  // Full-resolution line lengths in pixels
  localparam logic [LEN_W-1:0] LEN_2K = 14'h0800;
  localparam logic [LEN_W-1:0] LEN_4K = 14'h1000;
  localparam logic [LEN_W-1:0] LEN_8K = 14'h2000;

  // Line sequencer
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_ARMED, SEQ_SEND} seq_state_e;
endpackage : line_video_pkg
`default_nettype wire

// >>> verilog/line_video_out.sv
// Pixel FIFO and four-tap line video output with its register slave
//
// Added by the designer: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none

// ============================================================================
// Pixel group FIFO
module pixel_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 16,
  parameter int LVL_W = 5
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic in_valid,
  output var logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [LVL_W-1:0] level
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [LVL_W-1:0] FULL_LVL = LVL_W'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr_ff;
  logic [PTR_W-1:0] rd_ptr_ff;
  logic [LVL_W-1:0] count_ff;
  logic [LVL_W-1:0] nxt_count;
  logic ready_ff;
  logic push;
  logic pop;

  assign push = in_valid && ready_ff;
  assign pop = out_valid && out_ready;
  assign out_valid = (count_ff != '0);
  assign out_data = mem[rd_ptr_ff];
  assign level = count_ff;
  assign in_ready = ready_ff;

  // Occupancy after this cycle's push and pop
  always_comb begin
    nxt_count = count_ff;
    if (push && !pop) begin
      nxt_count = count_ff + LVL_W'(1);
    end else if (pop && !push) begin
      nxt_count = count_ff - LVL_W'(1);
    end
  end

  // Ready is registered so the source sees a clean flop
  always_ff @(posedge clk) begin
    if (reset) begin
      count_ff <= '0;
      ready_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      ready_ff <= (nxt_count != FULL_LVL);
    end
  end

  // Pointers wrap naturally, depth is a power of two
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + PTR_W'(1);
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + PTR_W'(1);
      end
    end
  end

  // Storage carries no reset
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end
endmodule : pixel_fifo

// ============================================================================
// Overview of operation
// - Outside valid line data both flags are driven low every cycle.
// - A line starts only after sensor readout has completed.
// - First valid cycle raises both flags with pixels 1..4 on taps 0..3.
// - Each next cycle keeps line valid high; data valid and the next four pixels follow unless the FIFO is empty.
// - After the line's last pixels both flags fall together next cycle.
// - Tap pixel width follows the selected 12, 10 or 8 bit mode.
// - Full line length is 8192, 4096 or 2048 pixels per variant.
// - Horizontal binning halves the line length.
// - With the region window active its length sets pixels per line.
// - 12 bit X: tap0 low on A, high on B0-3; tap1 high B4-7, low C.
// - 12 bit Y: tap3 low on D; tap2 low E, high F0-3; tap3 high F4-7.
// - 10 bit keeps 12 bit placement; lines for bits 10 and 11 unused.
// - 8 bit: taps 0,1,2 on A,B,C, tap 3 on D; E and F unused.
// - Both transmitters carry flags and clock; frame valid and spare unused.
// - 10 bit mode drops the two converter LSBs.
// - 8 bit mode drops the four converter LSBs.
// - Taps and flags launch on each rising edge of the pixel clock.
module line_video_out
  import line_video_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic pix_valid,
  output logic pix_ready,
  input wire logic [WORD_W-1:0] pix_data,
  input wire logic readout_done,
  input wire logic link_pclk,
  output logic [7:0] port_a,
  output logic [7:0] port_b,
  output logic [7:0] port_c,
  output logic [7:0] port_d,
  output logic [7:0] port_e,
  output logic [7:0] port_f,
  output logic line_valid_x,
  output logic data_valid_x,
  output logic frame_valid_x,
  output logic spare_x,
  output logic pclk_x,
  output logic line_valid_y,
  output logic data_valid_y,
  output logic frame_valid_y,
  output logic spare_y,
  output logic pclk_y
);
  // ==========================================================================
  // Declarations
  logic [6:0] ctrl_ff;
  logic [LEN_W-1:0] win_ff;
  logic under_ff;
  logic [CNT_W-1:0] line_cnt_ff;
  logic [31:0] rdata_ff;
  logic ready_out_ff;
  logic wr_pend_ff;
  logic [31:0] wr_addr_ff;
  logic pclk_meta_ff;
  logic pclk_sync_ff;
  logic pclk_prev_ff;
  logic pclk_out_ff;
  logic pix_rise;
  seq_state_e state_ff;
  logic [1:0] mode_ff;
  logic [GRP_W-1:0] groups_ff;
  logic [GRP_W-1:0] nxt_groups;
  logic [LEN_W-1:0] full_len;
  logic [LEN_W-1:0] line_len;
  logic [GRP_W-1:0] sent_ff;
  logic lval_ff;
  logic dval_ff;
  logic [7:0] pa_ff, pb_ff, pc_ff, pd_ff, pe_ff, pf_ff;
  logic fifo_valid;
  logic fifo_pop;
  logic [WORD_W-1:0] fifo_data;
  logic [LVL_W-1:0] fifo_level;
  logic line_end;
  logic under_set;
  logic [PIX_W-1:0] tap [4];
  logic [PIX_W-1:0] red [4];

  // ==========================================================================
  // AHB-Lite slave: zero wait states, always OKAY
  logic addr_phase;
  logic [31:0] rd_mux;
  assign addr_phase = hsel && hready && htrans[1];

  // Read value picked in the address phase, shown in the data phase
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (haddr == CTRL_ADDR) begin
      rd_mux[6:0] = ctrl_ff;
    end else if (haddr == WIN_ADDR) begin
      rd_mux[LEN_W-1:0] = win_ff;
    end else if (haddr == STAT_ADDR) begin
      rd_mux[ST_ACTIVE_BIT] = (state_ff != SEQ_IDLE);
      rd_mux[ST_UNDER_BIT] = under_ff;
      rd_mux[ST_LEVEL_LSB +: LVL_W] = fifo_level;
      rd_mux[ST_COUNT_LSB +: CNT_W] = line_cnt_ff;
    end
  end

  // Bus phase tracking
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 32'h0000_0000;
      rdata_ff <= 32'h0000_0000;
      ready_out_ff <= 1'b1;
    end else begin
      ready_out_ff <= 1'b1;
      if (hready) begin
        wr_pend_ff <= addr_phase && hwrite;
        wr_addr_ff <= haddr;
        rdata_ff <= (addr_phase && !hwrite) ? rd_mux : 32'h0000_0000;
      end
    end
  end

  // Control registers; unmapped writes are dropped
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl_ff <= CTRL_RST;
      win_ff <= WIN_RST;
    end else if (wr_pend_ff) begin
      if (wr_addr_ff == CTRL_ADDR) begin
        ctrl_ff <= hwdata[6:0];
      end
      if (wr_addr_ff == WIN_ADDR) begin
        win_ff <= hwdata[LEN_W-1:0];
      end
    end
  end

  // Underrun flag: write one to clear, a new underrun wins
  assign under_set = (state_ff == SEQ_SEND) && pix_rise && !line_end &&
                     !fifo_valid;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      under_ff <= 1'b0;
    end else if (under_set) begin
      under_ff <= 1'b1;
    end else if (wr_pend_ff && wr_addr_ff == STAT_ADDR &&
                 hwdata[ST_UNDER_BIT]) begin
      under_ff <= 1'b0;
    end
  end

  assign hreadyout = ready_out_ff;
  assign hrdata = rdata_ff;
  assign hresp = 1'b0;

  // ==========================================================================
  // Pixel clock sampling; the second and third stages feed the edge detector
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pclk_meta_ff <= 1'b0;
      pclk_sync_ff <= 1'b0;
      pclk_prev_ff <= 1'b0;
      pclk_out_ff <= 1'b0;
    end else begin
      pclk_meta_ff <= link_pclk;
      pclk_sync_ff <= pclk_meta_ff;
      pclk_prev_ff <= pclk_sync_ff;
      pclk_out_ff <= pclk_sync_ff;
    end
  end
  assign pix_rise = pclk_sync_ff && !pclk_prev_ff;

  // ==========================================================================
  // Line buffer between sensor readout and the taps
  pixel_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH),
    .LVL_W(LVL_W)
  ) u_fifo (
    .clk(ref_clk),
    .reset(reset),
    .in_valid(pix_valid),
    .in_ready(pix_ready),
    .in_data(pix_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data),
    .level(fifo_level)
  );

  // ==========================================================================
  // Line length in four-pixel groups
  always_comb begin
    case (ctrl_ff[CTRL_VAR_LSB +: 2])
      VAR_8K: full_len = LEN_8K;
      VAR_4K: full_len = LEN_4K;
      default: full_len = LEN_2K;
    endcase
    if (ctrl_ff[CTRL_WIN_BIT]) begin
      line_len = win_ff;
    end else if (ctrl_ff[CTRL_BIN_BIT]) begin
      line_len = full_len >> 1;
    end else begin
      line_len = full_len;
    end
    // Odd tail pixels are dropped; a tiny window still sends one group
    nxt_groups = line_len[LEN_W-1:2];
    if (nxt_groups == '0) begin
      nxt_groups = GRP_W'(1);
    end
  end

  assign line_end = (sent_ff >= groups_ff);
  assign fifo_pop = pix_rise && fifo_valid &&
                    ((state_ff == SEQ_ARMED) ||
                     (state_ff == SEQ_SEND && !line_end));

  // ==========================================================================
  // Line sequencer; mode and length are frozen per line
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_ff <= SEQ_IDLE;
      mode_ff <= MODE_12;
      groups_ff <= '0;
      sent_ff <= '0;
      line_cnt_ff <= '0;
    end else begin
      case (state_ff)
        SEQ_IDLE: begin
          if (readout_done && ctrl_ff[CTRL_EN_BIT]) begin
            state_ff <= SEQ_ARMED;
            mode_ff <= ctrl_ff[CTRL_MODE_LSB +: 2];
            groups_ff <= nxt_groups;
          end
        end
        SEQ_ARMED: begin
          if (fifo_pop) begin
            state_ff <= SEQ_SEND;
            sent_ff <= GRP_W'(1);
          end
        end
        SEQ_SEND: begin
          if (pix_rise && line_end) begin
            state_ff <= SEQ_IDLE;
            line_cnt_ff <= line_cnt_ff + CNT_W'(1);
          end else if (fifo_pop) begin
            sent_ff <= sent_ff + GRP_W'(1);
          end
        end
        default: state_ff <= SEQ_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Pixel depth reduction per tap
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_tap
      assign tap[g] = fifo_data[g*PIX_W +: PIX_W];
      always_comb begin
        case (mode_ff)
          MODE_10: red[g] = {2'h0, tap[g][11:2]};
          MODE_8: red[g] = {4'h0, tap[g][11:4]};
          default: red[g] = tap[g];
        endcase
      end
    end
  endgenerate

  // Flags: launched only on pixel clock rising edges
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      lval_ff <= 1'b0;
      dval_ff <= 1'b0;
    end else if (pix_rise) begin
      if (state_ff == SEQ_ARMED) begin
        lval_ff <= fifo_valid;
        dval_ff <= fifo_valid;
      end else if (state_ff == SEQ_SEND && !line_end) begin
        lval_ff <= 1'b1;
        // A starved buffer holds data valid low rather than repeat pixels
        dval_ff <= fifo_valid;
      end else begin
        lval_ff <= 1'b0;
        dval_ff <= 1'b0;
      end
    end
  end

  // Tap ports: placement by mode, zero when idle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      {pa_ff, pb_ff, pc_ff, pd_ff, pe_ff, pf_ff} <= '0;
    end else if (pix_rise) begin
      if (fifo_pop) begin
        if (mode_ff == MODE_8) begin
          pa_ff <= red[0][7:0];
          pb_ff <= red[1][7:0];
          pc_ff <= red[2][7:0];
          pd_ff <= red[3][7:0];
          pe_ff <= 8'h00;
          pf_ff <= 8'h00;
        end else begin
          // Ten bit values leave bits 10 and 11 at zero here
          pa_ff <= red[0][7:0];
          pb_ff <= {red[1][11:8], red[0][11:8]};
          pc_ff <= red[1][7:0];
          pd_ff <= red[3][7:0];
          pe_ff <= red[2][7:0];
          pf_ff <= {red[3][11:8], red[2][11:8]};
        end
      end else begin
        {pa_ff, pb_ff, pc_ff, pd_ff, pe_ff, pf_ff} <= '0;
      end
    end
  end

  // Both transmitters mirror the same flags and clock
  assign port_a = pa_ff;
  assign port_b = pb_ff;
  assign port_c = pc_ff;
  assign port_d = pd_ff;
  assign port_e = pe_ff;
  assign port_f = pf_ff;
  assign line_valid_x = lval_ff;
  assign data_valid_x = dval_ff;
  assign line_valid_y = lval_ff;
  assign data_valid_y = dval_ff;
  assign pclk_x = pclk_out_ff;
  assign pclk_y = pclk_out_ff;
  assign frame_valid_x = 1'b0;
  assign spare_x = 1'b0;
  assign frame_valid_y = 1'b0;
  assign spare_y = 1'b0;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  idle_flags_low_a: assert property (
      state_ff == SEQ_IDLE |-> !lval_ff && !dval_ff)
    else $error("flags high while idle");
  start_after_arm_a: assert property (
      $rose(lval_ff) |-> $past(state_ff) == SEQ_ARMED)
    else $error("line began without readout done");
  first_cycle_a: assert property (
      $rose(lval_ff) |-> dval_ff && sent_ff == GRP_W'(1))
    else $error("first cycle flags or count wrong");
  hold_between_a: assert property (
      lval_ff && !pix_rise |=> lval_ff && $stable(pa_ff))
    else $error("output moved off a pixel edge");
  line_drop_a: assert property (
      state_ff == SEQ_SEND && pix_rise && line_end |=> !lval_ff && !dval_ff)
    else $error("flags not dropped after last group");
  line_len_a: assert property (
      $fell(lval_ff) |-> sent_ff == groups_ff)
    else $error("wrong number of groups in line");
  full_8k_a: assert property (
      $rose(state_ff == SEQ_ARMED) && $past(ctrl_ff[5:2]) == 4'h2 |->
      groups_ff == 12'h800)
    else $error("8k line length wrong");
  bin_2k_a: assert property (
      $rose(state_ff == SEQ_ARMED) && $past(ctrl_ff[5:2]) == 4'h4 |->
      groups_ff == 12'h100)
    else $error("binned 2k length wrong");
  window_len_a: assert property (
      $rose(state_ff == SEQ_ARMED) && $past(ctrl_ff[CTRL_WIN_BIT]) &&
      $past(win_ff) >= 14'h0004 |-> groups_ff == $past(win_ff[LEN_W-1:2]))
    else $error("window length ignored");
  map_12_a: assert property (
      pix_rise && fifo_pop && mode_ff == MODE_12 |=>
      pb_ff == {$past(fifo_data[23:20]), $past(fifo_data[11:8])} &&
      pd_ff == $past(fifo_data[43:36]))
    else $error("12 bit placement wrong");
  map_10_a: assert property (
      pix_rise && fifo_pop && mode_ff == MODE_10 |=>
      pa_ff == $past(fifo_data[9:2]) && pb_ff[3:2] == 2'h0 &&
      pf_ff[7:6] == 2'h0)
    else $error("10 bit placement wrong");
  map_8_a: assert property (
      pix_rise && fifo_pop && mode_ff == MODE_8 |=>
      pa_ff == $past(fifo_data[11:4]) && pe_ff == 8'h00 && pf_ff == 8'h00)
    else $error("8 bit placement wrong");
  reset_quiet_a: assert property (
      $past(reset) |-> !lval_ff && pa_ff == 8'h00)
    else $error("outputs not quiet after reset");

  line_done_c: cover property ($fell(lval_ff));
  underrun_c: cover property (under_set);
  mode8_line_c: cover property ($rose(lval_ff) && mode_ff == MODE_8);
  fifo_full_c: cover property (!pix_ready && pix_valid);
endmodule : line_video_out
`default_nettype wire

// >>> tb/grabber_model.sv
// Frame grabber model: captures four-tap groups using one transmitter's flags and clock
`timescale 1ns/1ns
`default_nettype none

// ==========================================================================
// Receiver
module grabber_model
  import line_video_pkg::*;
(
  input wire logic pclk,
  input wire logic [1:0] mode,
  input wire logic [7:0] port_a,
  input wire logic [7:0] port_b,
  input wire logic [7:0] port_c,
  input wire logic [7:0] port_d,
  input wire logic [7:0] port_e,
  input wire logic [7:0] port_f,
  input wire logic line_valid,
  input wire logic data_valid,
  output logic [WORD_W-1:0] grp,
  output logic [15:0] grp_cnt,
  output logic [15:0] line_cnt,
  output logic [15:0] last_len
);
  logic lv_prev;
  logic [15:0] run_len;

  // Counters start clean; the grabber has no reset pin
  initial begin
    grp = '0;
    grp_cnt = 16'h0;
    line_cnt = 16'h0;
    last_len = 16'h0;
    run_len = 16'h0;
    lv_prev = 1'b0;
  end

  // Capture mid-eye: the forwarded clock rises with the launch
  always @(negedge pclk) begin
    if (line_valid === 1'b1 && data_valid === 1'b1) begin
      case (mode)
        MODE_10: grp <= {2'h0, port_f[5:4], port_d, 2'h0, port_f[1:0], port_e,
          2'h0, port_b[5:4], port_c, 2'h0, port_b[1:0], port_a};
        MODE_8: grp <= {4'h0, port_d, 4'h0, port_c, 4'h0, port_b,
          4'h0, port_a};
        default: grp <= {port_f[7:4], port_d, port_f[3:0], port_e,
          port_b[7:4], port_c, port_b[3:0], port_a};
      endcase
      run_len <= run_len + 16'h1;
      grp_cnt <= grp_cnt + 16'h1;
    end
    // Falling line flag closes the line and reports its length
    if (lv_prev && line_valid === 1'b0) begin
      last_len <= run_len;
      run_len <= 16'h0;
      line_cnt <= line_cnt + 16'h1;
    end
    lv_prev <= (line_valid === 1'b1);
  end
endmodule : grabber_model
`default_nettype wire

// >>> tb/line_video_out_tb.sv
// Self-checking bench for the four-tap line video output
`timescale 1ns/1ns
`default_nettype none

module line_video_out_tb
  import line_video_pkg::*;
;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic link_pclk = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  wire logic hready;
  logic hreadyout, hresp;
  logic [31:0] hrdata;
  logic pix_valid = 1'b0;
  logic pix_ready;
  logic [WORD_W-1:0] pix_data = '0;
  logic readout_done = 1'b0;
  logic [7:0] port_a, port_b, port_c, port_d, port_e, port_f;
  logic line_valid_x, data_valid_x, frame_valid_x, spare_x, pclk_x;
  logic line_valid_y, data_valid_y, frame_valid_y, spare_y, pclk_y;
  logic [1:0] cur_mode = MODE_12;
  logic [WORD_W-1:0] grp;
  logic [15:0] grp_cnt, line_cnt, last_len;
  logic [WORD_W-1:0] src_q[$];
  logic [WORD_W-1:0] exp_q[$];
  logic [WORD_W-1:0] want;
  logic [15:0] exp_len[$];
  int err_total = 0;
  int tests_run = 0;
  int lines = 0;

  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;

  // ========================================================================
  // Clocks: link edges sit on odd nanoseconds, never on a system edge
  always #2 ref_clk = ~ref_clk;
  initial begin
    #1;
    forever #16 link_pclk = ~link_pclk;
  end

  line_video_out uut (.ref_clk(ref_clk), .reset(reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .pix_valid(pix_valid),
    .pix_ready(pix_ready), .pix_data(pix_data),
    .readout_done(readout_done), .link_pclk(link_pclk),
    .port_a(port_a), .port_b(port_b), .port_c(port_c), .port_d(port_d),
    .port_e(port_e), .port_f(port_f), .line_valid_x(line_valid_x),
    .data_valid_x(data_valid_x), .frame_valid_x(frame_valid_x),
    .spare_x(spare_x), .pclk_x(pclk_x), .line_valid_y(line_valid_y),
    .data_valid_y(data_valid_y), .frame_valid_y(frame_valid_y),
    .spare_y(spare_y), .pclk_y(pclk_y));

  grabber_model grabber (.pclk(pclk_x), .mode(cur_mode), .port_a(port_a),
    .port_b(port_b), .port_c(port_c), .port_d(port_d), .port_e(port_e),
    .port_f(port_f), .line_valid(line_valid_x), .data_valid(data_valid_x),
    .grp(grp), .grp_cnt(grp_cnt), .line_cnt(line_cnt),
    .last_len(last_len));

  // ========================================================================
  // Checking helpers
  task automatic check(input logic [47:0] seen, input logic [47:0] want);
    tests_run++;
    if (seen !== want) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  // Tap values as the grabber should see them after truncation
  function automatic logic [47:0] expect_grp(input logic [47:0] w,
    input logic [1:0] m);
    logic [47:0] r;
    for (int i = 0; i < 4; i++) begin
      case (m)
        MODE_10: r[12*i +: 12] = {2'h0, w[12*i+2 +: 10]};
        MODE_8: r[12*i +: 12] = {4'h0, w[12*i+4 +: 8]};
        default: r[12*i +: 12] = w[12*i +: 12];
      endcase
    end
    return r;
  endfunction : expect_grp

  // ========================================================================
  // Bus master: hold each phase until ready is seen at an edge
  task automatic bus(input logic w, input logic [31:0] a,
    input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge ref_clk);
    while (hready !== 1'b1) @(posedge ref_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge ref_clk);
    while (hready !== 1'b1) @(posedge ref_clk);
    rd = hrdata;
    // The slave must always answer OKAY
    check({47'h0, hresp}, 48'h0);
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] rd;
    bus(1'b1, a, d, rd);
  endtask : wr

  task automatic rd_val(input logic [31:0] a, output logic [47:0] v);
    logic [31:0] rd;
    bus(1'b0, a, 32'h0, rd);
    v = {16'h0, rd};
  endtask : rd_val

  // ========================================================================
  // Stimulus helpers
  task automatic load(input int n);
    logic [63:0] r;
    repeat (n) begin
      r = {$urandom(), $urandom()};
      src_q.push_back(r[47:0]);
    end
  endtask : load

  task automatic pulse();
    readout_done <= 1'b1;
    @(posedge ref_clk);
    readout_done <= 1'b0;
  endtask : pulse

  // Bounded wait so a stuck line shows as a short count
  task automatic wait_lines();
    int k;
    k = 0;
    while (line_cnt < lines && k < 20000) begin
      @(posedge ref_clk);
      k++;
    end
    check({32'h0, line_cnt}, {32'h0, lines[15:0]});
  endtask : wait_lines

  task automatic run_line(input logic [1:0] m, input logic [31:0] ctrl,
    input int g);
    cur_mode = m;
    // Mode field follows the mode the grabber decodes with
    wr(CTRL_ADDR, ctrl | {30'h0, m});
    load(g);
    exp_len.push_back(g[15:0]);
    pulse();
    lines++;
    wait_lines();
  endtask : run_line

  // ========================================================================
  // Source of pixel groups; expected taps noted when a group is taken
  always @(posedge ref_clk) begin
    if (pix_valid === 1'b1 && pix_ready === 1'b1) begin
      exp_q.push_back(expect_grp(src_q.pop_front(), cur_mode));
    end
    pix_valid <= (src_q.size() > 0);
    if (src_q.size() > 0) pix_data <= src_q[0];
  end

  // Every captured group against the oldest note, plus idle lines
  always @(grp_cnt) begin
    if (grp_cnt != 16'h0) begin
      want = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
      check(grp, want);
      check({41'h0, line_valid_y, data_valid_y, frame_valid_x, spare_x,
        frame_valid_y, spare_y, pclk_y}, 48'h60);
    end
  end

  // Every finished line against its expected group count
  always @(line_cnt) begin
    if (line_cnt != 16'h0) begin
      check({32'h0, last_len}, {32'h0, exp_len.pop_front()});
    end
  end

  // ========================================================================
  // Main sequence
  initial begin
    logic [47:0] v;
    int g;
    void'($urandom(29));
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    check({port_a, port_b, port_c, port_d, port_e, port_f}, 48'h0);
    check({44'h0, line_valid_x, data_valid_x, line_valid_y,
      data_valid_y}, 48'h0);
    rd_val(CTRL_ADDR, v);
    check(v, {41'h0, CTRL_RST});
    rd_val(WIN_ADDR, v);
    check(v, {34'h0, WIN_RST});
    rd_val(STAT_ADDR, v);
    check(v, 48'h0);
    wr(32'h0000_000c, 32'hffff_ffff);
    rd_val(32'h0000_000c, v);
    check(v, 48'h0);
    // Readout while disabled must not arm a line
    wr(CTRL_ADDR, 32'h20);
    pulse();
    rd_val(STAT_ADDR, v);
    check(v, 48'h0);
    // Full FIFO with no readout yet: nothing may leave
    cur_mode = MODE_12;
    wr(WIN_ADDR, 32'd80);
    wr(CTRL_ADDR, 32'h60);
    load(20);
    repeat (60) @(posedge ref_clk);
    check({47'h0, pix_ready}, 48'h0);
    rd_val(STAT_ADDR, v);
    check(v, 48'h40);
    check({32'h0, grp_cnt}, 48'h0);
    check({46'h0, line_valid_x, data_valid_x}, 48'h0);
    exp_len.push_back(16'd20);
    pulse();
    lines++;
    wait_lines();
    // Window lines in each output mode, one of a single group
    for (int m = 0; m < 3; m++) begin
      g = (m == 0) ? 1 : 2 + $urandom_range(14, 0);
      wr(WIN_ADDR, g * 4);
      run_line(m[1:0], 32'h60 | m, g);
    end
    // Full resolution lines per variant, with and without binning
    for (int vr = 0; vr < 3; vr++) begin
      for (int b = 0; b < 2; b++) begin
        g = (vr == 0) ? LEN_2K : (vr == 1) ? LEN_4K : LEN_8K;
        g = (g >> 2) >> b;
        run_line(2'($urandom_range(2, 0)),
          32'h40 | (b << 4) | (vr << 2), g);
      end
    end
    // Starved line: flags hold line valid only, new readout is ignored
    cur_mode = MODE_12;
    wr(WIN_ADDR, 32'd32);
    wr(CTRL_ADDR, 32'h60);
    load(3);
    exp_len.push_back(16'd8);
    pulse();
    repeat (200) @(posedge ref_clk);
    check({46'h0, line_valid_x, data_valid_x}, 48'h2);
    pulse();
    rd_val(STAT_ADDR, v);
    check(v, {16'h0, lines[15:0], 16'h3});
    load(5);
    lines++;
    wait_lines();
    repeat (40) @(posedge ref_clk);
    wr(STAT_ADDR, 32'h2);
    rd_val(STAT_ADDR, v);
    check(v, {16'h0, lines[15:0], 16'h0});
    check({47'h0, data_valid_x}, 48'h0);
    give_verdict();
  end

  // Watchdog: the whole run needs well under this span
  initial begin
    #400000;
    err_total++;
    $display("unexpected at %0t: run did not finish", $time);
    give_verdict();
  end
endmodule : line_video_out_tb
`default_nettype wire
